// file: verilog/psu_param_store.sv
// parameter store: working copy, effective copy, 16-bit register access
// assumes the link decoder, motion logic and commit path share clk
`default_nettype none


module psu_param_store
	import psu_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// register access from the link decoder
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [PSU_RADDR_W-1:0] reg_addr,
	input  wire logic [PSU_HALF_W-1:0]  reg_wdata,
	output var  logic [PSU_HALF_W-1:0]  reg_rdata,
	output var  logic                   reg_ack,
	// update triggers
	input  wire logic                   motion_busy,
	input  wire logic                   cfg_cmd,
	// retained store commit path
	input  wire logic                   nv_wr,
	input  wire logic [PSU_IDX_W-1:0]   nv_addr,
	input  wire logic [PSU_DATA_W-1:0]  nv_wdata,
	// effective values for the drive logic
	input  wire logic [PSU_IDX_W-1:0]   act_addr,
	output var  logic [PSU_DATA_W-1:0]  act_data,
	output var  logic [PSU_NPARAM-1:0]  upd,
	output var  logic [PSU_NPARAM-1:0]  pend,
	output var  logic                   boot_busy
);

	typedef struct packed {
		psu_state_t                            state;
		logic [PSU_IDX_W:0]                    boot_cnt;
		logic [PSU_NPARAM-1:0][PSU_DATA_W-1:0] ram;
		logic [PSU_NPARAM-1:0][PSU_DATA_W-1:0] active;
		logic [PSU_NPARAM-1:0]                 pend;
		logic [PSU_HALF_W-1:0]                 wr_hold;
		logic [PSU_HALF_W-1:0]                 rd_hold;
		logic [PSU_HALF_W-1:0]                 reg_rdata;
		logic                                  reg_ack;
		logic [PSU_DATA_W-1:0]                 act_data;
		logic [PSU_NPARAM-1:0]                 upd;
		logic                                  boot_busy;
	} psu_top_t;

	psu_top_t                r;
	psu_top_t                next_r;
	logic [PSU_DATA_W-1:0]   nv_rdata;
	logic [PSU_IDX_W-1:0]    nv_raddr;
	logic [PSU_IDX_W-1:0]    boot_idx;
	logic [PSU_IDX_W-1:0]    reg_idx;
	logic                    reg_low;
	logic                    reg_map;
	logic [PSU_DATA_W-1:0]   wr_word;

	// ------------------------------------------------------------
	// retained store
	// ------------------------------------------------------------
	psu_nv_mem u_nv (
		.clk   (clk),
		.nrst  (nrst),
		.raddr (nv_raddr),
		.rdata (nv_rdata),
		.wr    (nv_wr),
		.waddr (nv_addr),
		.wdata (nv_wdata)
	);

	// access decode shared by both paths
	assign nv_raddr = r.boot_cnt[PSU_IDX_W-1:0];
	assign boot_idx = PSU_IDX_W'(r.boot_cnt - 1'b1);
	assign reg_idx  = psu_idx_of(reg_addr);
	assign reg_low  = psu_is_low(reg_addr);
	assign reg_map  = reg_addr < PSU_RADDR_W'(PSU_NREG);
	assign wr_word  = {r.wr_hold, reg_wdata};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.reg_ack = 1'b0;
		next_r.upd = '0;
		next_r.act_data = r.active[act_addr];
		unique case (r.state)
			// copy one word per cycle; read data lags the address by one
			PSU_BOOT: begin
				if (r.boot_cnt != '0) begin
					next_r.ram[boot_idx] = nv_rdata;
					next_r.active[boot_idx] = nv_rdata;
					next_r.upd[boot_idx] = 1'b1;
				end
				if (r.boot_cnt == (PSU_IDX_W + 1)'(PSU_NPARAM)) begin
					next_r.state = PSU_RUN;
					next_r.boot_busy = 1'b0;
				end else begin
					next_r.boot_cnt = r.boot_cnt + 1'b1;
				end
			end
			PSU_RUN: begin
				// deferred updates use the working copy as it stood
				for (int i = 0; i < PSU_NPARAM; i++) begin
					if (r.pend[i] && psu_class_of(PSU_IDX_W'(i)) == PSU_CLS_B && !motion_busy) begin
						next_r.active[i] = r.ram[i];
						next_r.pend[i] = 1'b0;
						next_r.upd[i] = 1'b1;
					end
					if (r.pend[i] && psu_class_of(PSU_IDX_W'(i)) == PSU_CLS_C && cfg_cmd) begin
						next_r.active[i] = r.ram[i];
						next_r.pend[i] = 1'b0;
						next_r.upd[i] = 1'b1;
					end
				end
				// a write in the same cycle sets its flag after the clear above
				if (reg_wr && reg_map) begin
					next_r.reg_ack = 1'b1;
					if (!reg_low) begin
						next_r.wr_hold = reg_wdata;
					end else begin
						next_r.ram[reg_idx] = wr_word;
						unique case (psu_class_of(reg_idx))
							PSU_CLS_A: begin
								next_r.active[reg_idx] = wr_word;
								next_r.upd[reg_idx] = 1'b1;
							end
							PSU_CLS_B, PSU_CLS_C: next_r.pend[reg_idx] = 1'b1;
							PSU_CLS_D: next_r.pend[reg_idx] = 1'b0;
						endcase
					end
				end else if (reg_wr) begin
					next_r.reg_ack = 1'b1;
				end
				// upper read snapshots the lower half so the pair is coherent
				if (reg_rd && !reg_wr) begin
					next_r.reg_ack = 1'b1;
					if (!reg_map) begin
						next_r.reg_rdata = PSU_HALF_RST;
					end else if (!reg_low) begin
						next_r.reg_rdata = r.ram[reg_idx][PSU_DATA_W-1:PSU_HALF_W];
						next_r.rd_hold = r.ram[reg_idx][PSU_HALF_W-1:0];
					end else begin
						next_r.reg_rdata = r.rd_hold;
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// the working copy clears at reset: nothing there survives power loss
	always_ff @(posedge clk) begin
		if (!nrst) begin
			r.state     <= PSU_BOOT;
			r.boot_cnt  <= '0;
			r.ram       <= {PSU_NPARAM{PSU_RAM_RST}};
			r.active    <= {PSU_NPARAM{PSU_RAM_RST}};
			r.pend      <= '0;
			r.wr_hold   <= PSU_HALF_RST;
			r.rd_hold   <= PSU_HALF_RST;
			r.reg_rdata <= PSU_HALF_RST;
			r.reg_ack   <= 1'b0;
			r.act_data  <= PSU_RAM_RST;
			r.upd       <= '0;
			r.boot_busy <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata = r.reg_rdata;
	assign reg_ack   = r.reg_ack;
	assign act_data  = r.act_data;
	assign upd       = r.upd;
	assign pend      = r.pend;
	assign boot_busy = r.boot_busy;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_ram_lost_reset: assert property (
		r.state == PSU_BOOT && r.boot_cnt == '0 |-> r.ram == '0)
		else $error("working copy not cleared at reset");

	// nine busy cycles: eight counted, the ninth is the one that moves to run
	a_boot_length: assert property (
		r.state == PSU_BOOT && r.boot_cnt == '0
		|-> r.boot_busy [*8] ##1 r.boot_busy ##1 (!r.boot_busy && r.state == PSU_RUN))
		else $error("power-up copy took the wrong time");

	a_boot_copy: assert property (
		r.state == PSU_BOOT && r.boot_cnt != '0 |=> r.active[$past(boot_idx)] == $past(nv_rdata))
		else $error("retained value not copied in");

	a_pair_write: assert property (
		r.state == PSU_RUN && reg_wr && reg_map && reg_low
		|=> r.ram[$past(reg_idx)] == {$past(r.wr_hold), $past(reg_wdata)} && r.reg_ack)
		else $error("pair write did not form the word");

	a_class_a_now: assert property (
		r.state == PSU_RUN && reg_wr && reg_map && reg_low && psu_class_of(reg_idx) == PSU_CLS_A
		|=> r.active[$past(reg_idx)] == $past(wr_word) && r.upd[$past(reg_idx)])
		else $error("class A value not applied at once");

	a_upper_read: assert property (
		r.state == PSU_RUN && reg_rd && !reg_wr && reg_map && !reg_low
		|=> r.reg_ack && r.reg_rdata == $past(r.ram[reg_idx][PSU_DATA_W-1:PSU_HALF_W]))
		else $error("upper register read wrong half");

	a_act_read: assert property (
		1'b1 |=> act_data == $past(r.active[act_addr]))
		else $error("effective value read wrong");

	for (genvar g = 0; g < PSU_NPARAM; g++) begin : g_chk
		a_b_deferred: assert property (
			r.state == PSU_RUN && r.pend[g] && psu_class_of(PSU_IDX_W'(g)) == PSU_CLS_B && motion_busy
			|=> $stable(r.active[g]))
			else $error("class B applied while moving");

		a_b_applied: assert property (
			r.state == PSU_RUN && r.pend[g] && psu_class_of(PSU_IDX_W'(g)) == PSU_CLS_B && !motion_busy
			|=> r.active[g] == $past(r.ram[g]) && r.upd[g])
			else $error("class B not applied after stop");

		a_c_on_config: assert property (
			r.state == PSU_RUN && psu_class_of(PSU_IDX_W'(g)) == PSU_CLS_C && !cfg_cmd
			|=> $stable(r.active[g]))
			else $error("class C changed without configuration");

		a_d_held: assert property (
			r.state == PSU_RUN && psu_class_of(PSU_IDX_W'(g)) == PSU_CLS_D
			|=> $stable(r.active[g]))
			else $error("class D changed before power-up");
	end

endmodule

`default_nettype wire

// file: pkg/psu_pkg.sv
// parameter store constants: sizes, update classes, register pairing
// assumes one 50 MHz system clock and a synchronous power-on reset
`default_nettype none

package psu_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int PSU_NPARAM   = 8;              // parameters held
	localparam int PSU_IDX_W    = 3;              // parameter index width
	localparam int PSU_DATA_W   = 32;             // every item is one 32-bit word
	localparam int PSU_HALF_W   = 16;             // protocol register width
	localparam int PSU_NREG     = 2 * PSU_NPARAM; // two registers per item
	localparam int PSU_RADDR_W  = 8;              // register number width
	localparam int PSU_HALF_BIT = 0;              // set: bits 15..0 half

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [PSU_DATA_W-1:0] PSU_RAM_RST  = 32'h0000_0000;
	localparam logic [PSU_HALF_W-1:0] PSU_HALF_RST = 16'h0000;

	// ------------------------------------------------------------
	// update classes and control states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PSU_CLS_A = 2'b00, // effective at once
		PSU_CLS_B = 2'b01, // after motion stops
		PSU_CLS_C = 2'b10, // after configuration or power-up
		PSU_CLS_D = 2'b11  // after power-up only
	} psu_class_t;

	typedef enum logic {
		PSU_BOOT = 1'b0,
		PSU_RUN  = 1'b1
	} psu_state_t;

	// class of each parameter: two of each kind
	function automatic psu_class_t psu_class_of(input logic [PSU_IDX_W-1:0] idx);
		case (idx)
			3'h0, 3'h1: return PSU_CLS_A;
			3'h2, 3'h3: return PSU_CLS_B;
			3'h4, 3'h5: return PSU_CLS_C;
			default:    return PSU_CLS_D;
		endcase
	endfunction

	// register number to parameter index
	function automatic logic [PSU_IDX_W-1:0] psu_idx_of(input logic [PSU_RADDR_W-1:0] a);
		return PSU_IDX_W'(a >> 1);
	endfunction

	// higher-numbered register of a pair carries the low half
	function automatic logic psu_is_low(input logic [PSU_RADDR_W-1:0] a);
		return a[PSU_HALF_BIT];
	endfunction

endpackage

`default_nettype wire

// file: verilog/psu_nv_mem.sv
// retained parameter store with one read and one write port
// assumes writes come only from the commit path, never from the link
`default_nettype none

module psu_nv_mem
	import psu_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// read port, data one cycle later
	input  wire logic [PSU_IDX_W-1:0]  raddr,
	output var  logic [PSU_DATA_W-1:0] rdata,
	// commit write port
	input  wire logic                  wr,
	input  wire logic [PSU_IDX_W-1:0]  waddr,
	input  wire logic [PSU_DATA_W-1:0] wdata
);

	typedef struct packed {
		logic [PSU_NPARAM-1:0][PSU_DATA_W-1:0] mem;
		logic [PSU_DATA_W-1:0]                 rdata;
	} psu_nv_t;

	// an erased store reads as zero until its first commit, so the first boot copies no unknowns
	psu_nv_t r = '0;
	psu_nv_t next_r;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// read before write: a same-cycle write shows up one read later
	always_comb begin
		next_r = r;
		next_r.rdata = r.mem[raddr];
		if (wr) begin
			next_r.mem[waddr] = wdata;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// contents survive reset, standing in for retention across power loss
	always_ff @(posedge clk) begin
		if (!nrst) begin
			r.mem   <= r.mem;
			r.rdata <= PSU_RAM_RST;
		end else begin
			r <= next_r;
		end
	end

	assign rdata = r.rdata;

endmodule

`default_nettype wire

// file: verification/psu_host.sv
// host model: issues 16-bit register accesses to the parameter store
// assumes ack one cycle after each request pulse; drives at falling edge
`default_nettype none

module psu_host
	import psu_pkg::*;
(
	// clock
	input  wire logic                   clk,
	// requests
	output var  logic                   reg_wr,
	output var  logic                   reg_rd,
	output var  logic [PSU_RADDR_W-1:0] reg_addr,
	output var  logic [PSU_HALF_W-1:0]  reg_wdata,
	// answers
	input  wire logic [PSU_HALF_W-1:0]  reg_rdata,
	input  wire logic                   reg_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end

	// one pulse; caller lowers it with idle, so back-to-back stays legal
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		ok = reg_ack;
		q = reg_rdata;
	endtask

	// released lines show garbage, not the last value
	task automatic idle();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask

	// whole word: upper register first, lower commits
	task automatic wr32(input logic [2:0] k, input logic [31:0] v, output logic ok);
		logic [15:0] q;
		logic        o1;
		logic        o2;
		acc(1'b1, {4'h0, k, 1'b0}, v[31:16], q, o1);
		acc(1'b1, {4'h0, k, 1'b1}, v[15:0], q, o2);
		idle();
		ok = o1 & o2;
	endtask

	task automatic rd32(input logic [2:0] k, output logic [31:0] v, output logic ok);
		logic o1;
		logic o2;
		acc(1'b0, {4'h0, k, 1'b0}, 16'h0000, v[31:16], o1);
		acc(1'b0, {4'h0, k, 1'b1}, 16'h0000, v[15:0], o2);
		idle();
		ok = o1 & o2;
	endtask
endmodule

`default_nettype wire

// file: verification/testbench.sv
// testbench: parameter store against the host model
// assumes 50 MHz clock; inputs change at the falling edge
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import psu_pkg::*;

	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic        clk = 1'b0;
	logic        nrst, reg_wr, reg_rd, reg_ack, motion_busy, cfg_cmd, nv_wr, boot_busy, ok;
	logic [7:0]  reg_addr, upd, pend;
	logic [15:0] reg_wdata, reg_rdata, q;
	logic [2:0]  nv_addr, act_addr;
	logic [31:0] nv_wdata, act_data, v;
	int          n_mismatch = 0;
	int          n_tests = 0;

	always #10 clk = ~clk;

	psu_param_store psu_param_store_inst (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.motion_busy(motion_busy), .cfg_cmd(cfg_cmd), .nv_wr(nv_wr), .nv_addr(nv_addr),
		.nv_wdata(nv_wdata), .act_addr(act_addr), .act_data(act_data), .upd(upd), .pend(pend),
		.boot_busy(boot_busy));
	psu_host psu_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] nvv(input logic [2:0] k);
		return {8'h5a, 5'h00, k, 13'h0000, k};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic act_chk(input logic [2:0] k, input logic [31:0] exp);
		act_addr = k;
		@(negedge clk);
		chk(act_data, exp);
	endtask

	// pulse may already be showing, so look before waiting
	task automatic wait_upd(input int k);
		logic f;
		f = 1'b0;
		for (int i = 0; i < 4 && !f; i++) begin
			if (upd[k] === 1'b1) f = 1'b1;
			else @(negedge clk);
		end
		chk(f, 1'b1);
	endtask

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic power_up(input logic full);
		int          nb;
		logic [7:0]  seen;
		nrst = 1'b0;
		repeat (3) @(negedge clk);
		chk({boot_busy, pend, upd}, 17'h10000);
		nrst = 1'b1;
		nb = 0;
		seen = 8'h00;
		do begin
			@(negedge clk);
			seen |= upd;
			nb++;
		end while (boot_busy === 1'b1 && nb < 20);
		chk(nb, 9);
		chk(seen, 8'hff);
		for (int k = 0; k < 8 && full; k++) begin
			act_chk(3'(k), nvv(3'(k)));
			psu_host_inst.rd32(3'(k), v, ok);
			chk(v, nvv(3'(k)));
			chk({31'h0, ok}, 32'h1);
		end
	endtask

	task automatic t_class_a();
		psu_host_inst.wr32(3'd0, 32'h1234_5678, ok);
		chk({ok, upd}, 9'h101);
		@(negedge clk);
		psu_host_inst.acc(1'b0, 8'h00, 16'h0000, q, ok);
		chk(q, 16'h1234);
		psu_host_inst.acc(1'b0, 8'h01, 16'h0000, q, ok);
		chk(q, 16'h5678);
		psu_host_inst.idle();
		act_chk(3'd0, 32'h1234_5678);
	endtask

	task automatic t_class_b();
		motion_busy = 1'b1;
		psu_host_inst.wr32(3'd2, 32'hbeef_0002, ok);
		repeat (3) @(negedge clk);
		chk(pend, 8'h04);
		act_chk(3'd2, nvv(3'd2));
		motion_busy = 1'b0;
		wait_upd(2);
		act_chk(3'd2, 32'hbeef_0002);
		chk(pend, 8'h00);
	endtask

	task automatic t_class_c();
		psu_host_inst.wr32(3'd4, 32'hcafe_0004, ok);
		repeat (3) @(negedge clk);
		chk(pend, 8'h10);
		act_chk(3'd4, nvv(3'd4));
		cfg_cmd = 1'b1;
		@(negedge clk);
		cfg_cmd = 1'b0;
		wait_upd(4);
		act_chk(3'd4, 32'hcafe_0004);
	endtask

	// class D stays old through configuration; the next power-up restores retained values
	task automatic t_class_d();
		psu_host_inst.wr32(3'd6, 32'hd00d_0006, ok);
		cfg_cmd = 1'b1;
		@(negedge clk);
		cfg_cmd = 1'b0;
		repeat (3) @(negedge clk);
		chk(pend, 8'h00);
		act_chk(3'd6, nvv(3'd6));
		psu_host_inst.rd32(3'd6, v, ok);
		chk(v, 32'hd00d_0006);
		power_up(1'b1);
	endtask

	task automatic t_unmapped();
		psu_host_inst.acc(1'b0, 8'h40, 16'h0000, q, ok);
		chk({ok, q}, 17'h10000);
		psu_host_inst.acc(1'b1, 8'h41, 16'hffff, q, ok);
		chk({31'h0, ok}, 32'h1);
		psu_host_inst.idle();
		@(negedge clk);
		psu_host_inst.rd32(3'd0, v, ok);
		chk(v, 32'h1234_5678);
		@(negedge clk);
	endtask

	// ------------------------------------------------------------
	// sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{nrst, motion_busy, cfg_cmd, nv_wr} = 4'h0;
		{nv_addr, act_addr, nv_wdata} = '0;
		power_up(1'b0);
		for (int k = 0; k < 8; k++) begin
			nv_wr = 1'b1;
			nv_addr = 3'(k);
			nv_wdata = nvv(3'(k));
			@(negedge clk);
		end
		nv_wr = 1'b0;
		power_up(1'b1);
		t_class_a();
		t_class_b();
		t_class_c();
		t_unmapped();
		t_class_d();
		close_out();
	end

	// whole run is well under two hundred cycles; this is far beyond it
	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end
endmodule

`default_nettype wire
